// file: src/ascp_pkg.sv
// Package: constants and types for the converter serial port host controller
package ascp_pkg;
   // Wishbone register offsets (byte addresses)
   localparam logic [3:0] ASCP_REG_CTRL   = 4'h0;
   localparam logic [3:0] ASCP_REG_WORD   = 4'h4;
   localparam logic [3:0] ASCP_REG_STATUS = 4'h8;
   localparam logic [3:0] ASCP_REG_RESULT = 4'hC;
   // Control register fields
   localparam int ASCP_CTRL_GO     = 0;
   localparam int ASCP_CTRL_MODE   = 1;
   localparam int ASCP_CTRL_TIED   = 2;
   localparam int ASCP_CTRL_AUTO   = 3;
   localparam int ASCP_CTRL_CONTIN = 4;
   // Status register fields
   localparam int ASCP_ST_BUSY     = 0;
   localparam int ASCP_ST_DONE     = 1;
   localparam int ASCP_ST_TRIG     = 2;
   localparam int ASCP_ST_MODE     = 3;
   // Frame geometry
   localparam int ASCP_CW_BITS     = 5;
   localparam int ASCP_WR_CLOCKS   = 6;
   localparam int ASCP_FRAME_BITS  = 16;
   localparam int ASCP_RES_BITS    = 12;
   localparam logic [4:0] ASCP_CNT_ZERO = 5'h00;
   // Timing: host-made serial clock of 2.5 MHz at 50 MHz
   localparam int ASCP_CLK_MHZ     = 50;
   localparam int ASCP_SCLK_KHZ    = 2500;
   localparam int ASCP_HALF_CYC    = (ASCP_CLK_MHZ * 1000) / (2 * ASCP_SCLK_KHZ);
   localparam logic [7:0] ASCP_HALF_DEF = 8'(ASCP_HALF_CYC);
   // Transfer state machine
   typedef enum logic [2:0]
   {
      ASCP_IDLE  = 3'b000,
      ASCP_LOW   = 3'b001,
      ASCP_HIGH  = 3'b010,
      ASCP_DONE  = 3'b011,
      ASCP_SLAVE = 3'b100
   } ascp_state_t;
endpackage

// file: src/ascp_host.sv
// Host controller for the converter serial control port
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
module ascp_host
   import ascp_pkg::*;
#(
   // Serial clock half period in system clocks; the default gives 2.5 MHz.
   // At 1 each half, the first low time included, is one system clock; at 0 the divider wraps and each half takes 256.
   parameter logic [7:0] HALF_PERIOD = ascp_pkg::ASCP_HALF_DEF
)
(
   // Clock, reset and enable
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Device serial pins
   output logic             sclk_o,
   output logic             sclk_oe,
   input  wire logic        sclk_i,
   output logic             write_frame_n,
   output logic             read_frame_n_o,
   output logic             read_frame_n_oe,
   input  wire logic        read_frame_n_i,
   output logic             data_to_dev,
   input  wire logic        data_from_dev,
   output logic             clocking_mode_select,
   input  wire logic        conversion_trigger_n
);
   import ascp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      // Transfer control and the software-visible registers
      ascp_state_t st;
      logic [4:0]  ctrl;
      logic [4:0]  cword;
      // Shift registers and the last result of a tied frame
      logic [15:0] tx;
      logic [15:0] rx;
      logic [15:0] result;
      // Clock counting and the serial clock divider
      logic [4:0]  cnt;
      logic [4:0]  nbits;
      logic [7:0]  div;
      // Bus side
      logic        done;
      logic        ack;
      logic [31:0] rdat;
      // Registered pin drives, so decode changes never glitch a pin
      logic        sclk;
      logic        wfn;
      logic        rfn;
      logic        dout;
      // Synchronisers; only stage 0 sees the raw pin
      logic [2:0]  s_sclk;
      logic [2:0]  s_rfn;
      logic [1:0]  s_din;
      logic [2:0]  s_trig;
   } ascp_s_t;

   // All state in one register; d is its next value
   ascp_s_t q;
   ascp_s_t d;
   // Strobes decoded from registered or synchronised state, except wb_req, which also takes the raw bus request
   logic    wb_req;
   logic    ext_fall;
   logic    ext_rise;
   logic    frame_fall;
   logic    frame_rise;
   logic    host_mode;

   ////////////////////////////////////////////////////////////////////////////
   // Address match used by both the read and the write decode
   // Full four-bit compare: aliased registers would hide decode faults
   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = (a == r);
   endfunction

   // A request is taken once; the registered ack masks the held request
   assign wb_req     = wb_cyc_i && wb_stb_i && !q.ack;

   // Edge detection only looks at the second and third synchroniser stages.
   // This costs three system clocks on every device edge, which a device-made
   // clock of a few MHz leaves ample room for.
   assign ext_fall   = q.s_sclk[2] && !q.s_sclk[1];
   assign ext_rise   = !q.s_sclk[2] && q.s_sclk[1];
   assign frame_fall = q.s_rfn[2] && !q.s_rfn[1];
   assign frame_rise = !q.s_rfn[2] && q.s_rfn[1];
   assign host_mode  = q.ctrl[ASCP_CTRL_MODE];

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      d        = q;
      d.ack    = 1'b0;
      // Pins shift through their synchronisers on every enabled clock
      d.s_sclk = {q.s_sclk[1:0], sclk_i};
      d.s_rfn  = {q.s_rfn[1:0], read_frame_n_i};
      d.s_din  = {q.s_din[0], data_from_dev};
      d.s_trig = {q.s_trig[1:0], conversion_trigger_n};

      // Register bus: one-cycle answer, ack dropped the cycle after.
      // Writes land on the taking edge; the master holds them until ack anyway.
      if (wb_req)
      begin
         d.ack = 1'b1;
         // Only byte lane 0 holds writable register bits, so only its select gates writes
         if (wb_we_i && wb_sel_i[0])
         begin
            if (hit(wb_adr_i, ASCP_REG_CTRL))
            begin
               d.ctrl = wb_dat_i[4:0];
               d.ctrl[ASCP_CTRL_GO] = 1'b0;
               // Start only from idle and only in the mode already in force, so a
               // mode change and a start never share one write
               if (wb_dat_i[ASCP_CTRL_GO] && q.st == ASCP_IDLE
                   && host_mode == wb_dat_i[ASCP_CTRL_MODE])
               begin
                  d.ctrl[ASCP_CTRL_GO] = 1'b1;
               end
            end
            else if (hit(wb_adr_i, ASCP_REG_WORD))
            begin
               d.cword = wb_dat_i[4:0];
            end
            else if (hit(wb_adr_i, ASCP_REG_STATUS))
            begin
               // Done is write-one-to-clear; other bits of the word are ignored
               if (wb_dat_i[ASCP_ST_DONE])
               begin
                  d.done = 1'b0;
               end
            end
         end

         // Reads: registered, so read data stands with ack; unmapped reads give zero
         d.rdat = 32'h0000_0000;
         if (hit(wb_adr_i, ASCP_REG_CTRL))
         begin
            d.rdat[4:0] = q.ctrl;
         end
         else if (hit(wb_adr_i, ASCP_REG_WORD))
         begin
            d.rdat[4:0] = q.cword;
         end
         else if (hit(wb_adr_i, ASCP_REG_STATUS))
         begin
            d.rdat[ASCP_ST_BUSY] = (q.st != ASCP_IDLE);
            d.rdat[ASCP_ST_DONE] = q.done;
            d.rdat[ASCP_ST_TRIG] = q.s_trig[2];
            d.rdat[ASCP_ST_MODE] = host_mode;
         end
         else if (hit(wb_adr_i, ASCP_REG_RESULT))
         begin
            d.rdat[15:0] = q.result;
         end
      end

      // Transfer engine. Host mode times the whole frame from the divider;
      // device mode only follows the device's clock and shared frame.
      case (q.st)
         ASCP_IDLE:
         begin
            // Idle: clock low, both frames high, counters cleared
            d.sclk = 1'b0;
            d.wfn  = 1'b1;
            d.rfn  = 1'b1;
            d.cnt  = ASCP_CNT_ZERO;
            d.div  = 8'h00;
            // Word is loaded before any frame can fall
            d.tx   = {q.cword, 11'h000};
            // Frame length: sixteen clocks with tied frames, six for a write alone
            d.nbits = q.ctrl[ASCP_CTRL_TIED] ? 5'(ASCP_FRAME_BITS)
                                             : 5'(ASCP_WR_CLOCKS);
            if (!host_mode && q.ctrl[ASCP_CTRL_TIED])
            begin
               // Device makes clock and frame; follow its frame
               d.dout = q.cword[ASCP_CW_BITS-1];
               if (frame_fall)
               begin
                  d.st  = ASCP_SLAVE;
                  d.tx  = {q.cword, 11'h000} << 1;
               end
            end
            // Host mode starts on GO; device mode writes only through tied frames
            else if (q.ctrl[ASCP_CTRL_GO] && host_mode)
            begin
               d.ctrl[ASCP_CTRL_GO] = 1'b0;
               d.wfn  = 1'b0;
               d.rfn  = !q.ctrl[ASCP_CTRL_TIED];
               d.st   = ASCP_LOW;
            end
         end

         ASCP_LOW:
         begin
            // Clock low half; rising edge ends it with new data
            // The frame fall lands here too, so the first half is a full low time
            d.div = q.div + 8'h01;
            if (q.div == HALF_PERIOD - 8'h01)
            begin
               d.div  = 8'h00;
               d.sclk = 1'b1;
               // New bit goes out with the rise, a full half period before sampling
               d.dout = q.tx[15];
               d.tx   = q.tx << 1;
               d.st   = ASCP_HIGH;
            end
         end

         ASCP_HIGH:
         begin
            // Clock high half; the bit put out at the rise stands through it
            d.div = q.div + 8'h01;
            if (q.div == HALF_PERIOD - 8'h01)
            begin
               // Falling edge: sample the device's bit
               d.div  = 8'h00;
               d.sclk = 1'b0;
               d.rx   = {q.rx[14:0], q.s_din[1]};
               d.cnt  = q.cnt + 5'h01;
               // Frame ends one system clock after the last falling edge, so the read
               // is over as early as it can be for software timing
               d.st   = (q.cnt + 5'h01 == q.nbits) ? ASCP_DONE : ASCP_LOW;
            end
         end

         ASCP_SLAVE:
         begin
            // Device clock: drive on its rise, sample on its fall
            if (ext_rise)
            begin
               d.dout = q.tx[15];
               d.tx   = q.tx << 1;
            end
            // Count kept but never read, not even by status; the device's frame rise decides the end
            if (ext_fall)
            begin
               d.rx  = {q.rx[14:0], q.s_din[1]};
               d.cnt = q.cnt + 5'h01;
            end
            // A cut frame still ends here: only the frame rise closes it
            if (frame_rise)
            begin
               d.st = ASCP_DONE;
            end
         end

         ASCP_DONE:
         begin
            // Frame released; tied frame raise lets result update
            d.wfn  = 1'b1;
            d.rfn  = 1'b1;
            d.sclk = 1'b0;
            // Set after the bus clear above, so a finish beats a clear in one cycle
            d.done = 1'b1;
            // Untied frames read nothing, so the last result stays
            if (q.ctrl[ASCP_CTRL_TIED])
            begin
               d.result = q.rx;
            end
            // Continuous mode rearms GO, so the next frame starts from idle at once
            if (q.ctrl[ASCP_CTRL_CONTIN] && host_mode)
            begin
               d.ctrl[ASCP_CTRL_GO] = 1'b1;
            end
            d.st = ASCP_IDLE;
         end

         default:
         begin
            d.st = ASCP_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; clock enable freezes everything
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         // The clock, frame and trigger synchronisers start at the pins' pulled-up idle level, so the
         // edge detectors see no false edge once reset lets go
         q <= '{st: ASCP_IDLE, sclk: 1'b0, wfn: 1'b1, rfn: 1'b1,
                s_sclk: 3'b111, s_rfn: 3'b111, s_trig: 3'b111, default: '0};
      end
      // Enable low holds every field, the bus answer included
      else if (ce)
      begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs. Drive enables follow the mode bit: in host mode the clock and
   // read frame pins are driven here, in device mode the device owns them.
   assign wb_dat_o             = q.rdat;
   assign wb_ack_o             = q.ack;
   assign clocking_mode_select = host_mode;
   // Serial pins, each straight from a flip-flop
   assign sclk_o               = q.sclk;
   assign sclk_oe              = host_mode;
   assign read_frame_n_o       = q.rfn;
   assign read_frame_n_oe      = host_mode;
   assign write_frame_n        = q.wfn;
   assign data_to_dev          = q.dout;
endmodule

// file: dv/ascp_host_sva.sv
// Concurrent checks on the host controller's serial and bus ports
`timescale 1ns/10ps
module ascp_host_sva
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus answer
   input wire logic wb_ack_o,
   // Serial pins
   input wire logic sclk_o,
   input wire logic sclk_oe,
   input wire logic write_frame_n,
   input wire logic read_frame_n_o,
   input wire logic read_frame_n_oe,
   input wire logic data_to_dev,
   input wire logic clocking_mode_select
);
   import ascp_pkg::*;
   typedef struct packed {logic sclk; logic [4:0] cnt;} ascp_chk_t;
   ascp_chk_t st_q;
   ascp_chk_t st_d;
   ////////////////////////////////////////////////////////////////////////
   // Count clock rises in a write frame; idle clears it so frames never mix
   always_comb
   begin
      st_d      = st_q;
      st_d.sclk = sclk_o;
      st_d.cnt  = write_frame_n ? 5'h00 : st_q.cnt + 5'(sclk_o & ~st_q.sclk);
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         st_q <= '0;
      else
         st_q <= st_d;
   end
   ////////////////////////////////////////////////////////////////////////
   // Frame ends, split by whether the read frame was tied on
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_end_solo;
      $rose(write_frame_n) && $past(read_frame_n_o);
   endsequence
   sequence s_end_tied;
      $rose(write_frame_n) && !$past(read_frame_n_o);
   endsequence
   AST_IDLE_LOW: assert property (write_frame_n && sclk_oe |-> !sclk_o)
      else $error("serial clock not low between frames");
   AST_DATA_STABLE: assert property ($fell(sclk_o) |-> $stable(data_to_dev))
      else $error("data moved at falling clock");
   AST_DATA_CHG: assert property (!write_frame_n && $past(!write_frame_n)
      && $changed(data_to_dev) |-> $rose(sclk_o))
      else $error("data moved away from a rising clock");
   AST_FRAME_START: assert property ($fell(write_frame_n) |-> !sclk_o [*2])
      else $error("clock began with the frame");
   AST_SOLO_CNT: assert property (s_end_solo |-> st_q.cnt == 5'h06)
      else $error("write frame clock count wrong");
   AST_TIED_CNT: assert property (s_end_tied |-> st_q.cnt == 5'h10)
      else $error("tied frame clock count wrong");
   AST_TIED_FRAMES: assert property (read_frame_n_oe && !read_frame_n_o
      |-> !write_frame_n)
      else $error("read frame low outside write frame");
   AST_MODE_OE: assert property (sclk_oe == clocking_mode_select
      && read_frame_n_oe == clocking_mode_select)
      else $error("drive enables disagree with mode");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
endmodule
bind ascp_host ascp_host_sva chk_u (.clk(clk), .rst(rst), .wb_ack_o(wb_ack_o),
   .sclk_o(sclk_o), .sclk_oe(sclk_oe), .write_frame_n(write_frame_n),
   .read_frame_n_o(read_frame_n_o), .read_frame_n_oe(read_frame_n_oe),
   .data_to_dev(data_to_dev), .clocking_mode_select(clocking_mode_select));

// file: dv/ascp_dev_model.sv
// Behavioural converter serial port, host-clocked only; it makes no clock of its own
`timescale 1ns/10ps
module ascp_dev_model
(
   // Serial pins
   input  wire logic        sclk,
   input  wire logic        write_frame_n,
   input  wire logic        read_frame_n,
   input  wire logic        data_in,
   output logic             data_out,
   // Bench view
   input  wire logic [11:0] result,
   output logic       [4:0] ctrl_q
);
   logic [4:0]  sh_q = 5'h00;
   logic [3:0]  wcnt_q = 4'h0;
   logic [15:0] out_q = 16'h0000;
   initial ctrl_q = 5'h00;
   initial data_out = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // Write: five bits on falling clocks, loaded on the sixth; short frames lose it
   always @(negedge sclk or posedge write_frame_n)
   begin
      if (write_frame_n)
         wcnt_q <= 4'h0;
      else
      begin
         if (wcnt_q < 4'h5)
            sh_q <= {sh_q[3:0], data_in};
         if (wcnt_q == 4'h5)
            ctrl_q <= sh_q;
         if (wcnt_q < 4'h6)
            wcnt_q <= wcnt_q + 4'h1;
      end
   end
   // Read: result fixed at frame fall, so a new result waits for the next frame
   always @(posedge sclk or posedge read_frame_n or negedge read_frame_n)
   begin
      if (read_frame_n)
         data_out <= ~data_out; // Released line never shows the old bit
      else if (!sclk)
         out_q <= {1'b0, ctrl_q[4:2], result};
      else
      begin
         data_out <= out_q[15];
         out_q    <= {out_q[14:0], 1'b0};
      end
   end
endmodule

// file: dv/ascp_host_tb.sv
// Self-checking bench for the serial port host controller
`timescale 1ns/10ps
module ascp_host_tb;
   import ascp_pkg::*;
   logic        clk, rst, ce, cyc, we, trig_n;
   logic [3:0]  adr;
   logic [31:0] wdat, rdat, rd;
   logic        ack, sclk_o, sclk_oe, wfn, rfn_o, rfn_oe, dout_h, din_h, mode;
   logic [11:0] res;
   logic [4:0]  ctrl, w;
   int          bad_count, n_checks, k;
   wire         sclk_w = sclk_oe ? sclk_o : 1'b1; // Pull-ups on clock and frame
   wire         rfn_w  = rfn_oe ? rfn_o : 1'b1;
   always #10 clk = ~clk;
   ascp_host #(.HALF_PERIOD(8'h04)) dut_u (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .sclk_i(sclk_w),
      .write_frame_n(wfn), .read_frame_n_o(rfn_o), .read_frame_n_oe(rfn_oe),
      .read_frame_n_i(rfn_w), .data_to_dev(dout_h), .data_from_dev(din_h),
      .clocking_mode_select(mode), .conversion_trigger_n(trig_n));
   ascp_dev_model dev_u (.sclk(sclk_w), .write_frame_n(wfn), .read_frame_n(rfn_w),
      .data_in(dout_h), .data_out(din_h), .result(res), .ctrl_q(ctrl));
   ////////////////////////////////////////////////////////////////////////
   // One classic cycle; request held until ack is seen at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      we   <= wr;
      adr  <= a;
      wdat <= d;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (ack !== 1'b1 && t < 50);
      rd = rdat;
      cyc <= 1'b0;
      if (t >= 50)
         bad_count++;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   function automatic logic [31:0] exp_res(input logic [4:0] c, input logic [11:0] r);
      return {16'h0000, 1'b0, c[4:2], r};
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // A framed write, with the result read back when the frames are tied
   task automatic frame(input logic tied);
      logic [4:0]  prev;
      logic [11:0] r;
      int          n;
      logic [2:0]  hold;
      prev = ctrl;
      r    = 12'($urandom);
      res  = r;
      w    = 5'($urandom);
      n    = 0;
      bus(1'b1, ASCP_REG_WORD, {27'h0, w});
      bus(1'b1, ASCP_REG_CTRL, {29'h0, tied, 2'b11});
      bus(1'b0, ASCP_REG_STATUS, 32'h0);
      chk("busy", 32'h1, {31'h0, rd[ASCP_ST_BUSY]});
      // Enable low mid-frame must freeze the pins; the frame then resumes
      ce <= 1'b0;
      @(posedge clk);
      hold = {wfn, sclk_o, dout_h};
      repeat (6) @(posedge clk);
      chk("freeze", {29'h0, hold}, {29'h0, wfn, sclk_o, dout_h});
      ce <= 1'b1;
      do
      begin
         bus(1'b0, ASCP_REG_STATUS, 32'h0);
         n++;
      end
      while (rd[ASCP_ST_DONE] !== 1'b1 && n < 100);
      if (n >= 100)
         bad_count++;
      chk("ctrl", {27'h0, w}, {27'h0, ctrl});
      if (tied)
      begin
         bus(1'b0, ASCP_REG_RESULT, 32'h0);
         chk("result", exp_res(prev, r), rd);
      end
      bus(1'b1, ASCP_REG_STATUS, 32'h2);
      bus(1'b0, ASCP_REG_STATUS, 32'h0);
      chk("done_clr", 32'h0, {31'h0, rd[ASCP_ST_DONE]});
      $display("frame test done, tied %0d", tied);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, register checks, then a tied, an untied and six random frames
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      cyc = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      wdat = 32'h0;
      trig_n = 1'b1;
      res = 12'h000;
      bad_count = 0;
      n_checks = 0;
      void'($urandom(60422));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, ASCP_REG_STATUS, 32'h0);
      chk("status_rst", 32'h0, {28'h0, rd[3], 1'b0, rd[1:0]});
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, rd);
      for (k = 0; k < 4; k++)
      begin
         trig_n <= 1'($urandom);
         repeat (4) @(posedge clk);
         bus(1'b0, ASCP_REG_STATUS, 32'h0);
         chk("trig", {31'h0, trig_n}, {31'h0, rd[ASCP_ST_TRIG]});
      end
      bus(1'b1, ASCP_REG_CTRL, 32'h2);
      chk("mode", 32'h1, {31'h0, mode});
      $display("register test done");
      frame(1'b1);
      frame(1'b0);
      for (k = 0; k < 6; k++)
         frame(1'($urandom));
      print_verdict();
   end
   // Watchdog well beyond the expected run length
   initial
   begin
      #400000;
      bad_count++;
      print_verdict();
   end
endmodule
